// File: spg_pkg.sv
// package: constants and types for the shared pin gpio block
// Functional notes
// R1 - send request pin low or config bit asserts
// R2 - carrier pin follows carrier; rise/fall flags set
// R3 - alarm pin combines alarm sources
// R4 - uart mode soft interrupt via break request
// R5 - seven pins usable as gpio when free
// R6 - pin setup waits for interface mode known
// R7 - gpio needs enable bit and mode conditions
// R8 - open drain one and data one: input
// R9 - all gpio pins high impedance after init
// R10 - otherwise output, push-pull or pseudo open drain
// R11 - data read returns actual pin levels
// R12 - cs, sdi, sdo gpio only in register mode
// R13 - uart pins and carrier gpio when uart disabled
// R14 - clock pin gpio when clkout off and mode free
// R15 - spi mode irq enable: uart out is irq
// R16 - register mode irq enable: sdo is irq
// R17 - register mode clear enable: sdi is clear
// R18 - register mode blocks spi access
// R19 - active comm function overrides gpio settings
package spg_pkg;
    localparam int SPG_NPIN = 7;
    localparam logic [6:0] SPG_RST_PINS = 7'h00;
    // pin indices
    localparam int SPG_P_CLK = 0;
    localparam int SPG_P_CD = 1;
    localparam int SPG_P_UOUT = 2;
    localparam int SPG_P_UIN = 3;
    localparam int SPG_P_SDO = 4;
    localparam int SPG_P_SDI = 5;
    localparam int SPG_P_CS = 6;

    typedef struct packed {
        logic uart_register_mode_bit;
        logic uart_disable_bit;
        logic clear_input_enable;
        logic irq_pin_enable;
        logic clock_output_enable;
        logic soft_interrupt_enable;
        logic send_request_bit;
    } spg_cfg_t;

    typedef struct packed {
        logic [6:0] en;
        logic [6:0] pin_open_drain_select;
        logic [6:0] data;
    } spg_gpio_t;

    typedef enum logic [1:0] {
        SPG_WAIT = 2'h1,
        SPG_RUN = 2'h2
    } spg_state_t;
endpackage

// File: spg_pin_cell.sv
// one shared pin: gpio vs function drive and registered readback
`timescale 1ns/10ps
`default_nettype none
module spg_pin_cell
    import spg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ready,
    input wire logic gpio_sel,
    input wire logic func_drive,
    input wire logic func_out,
    input wire logic gpio_en,
    input wire logic od_sel,
    input wire logic data_bit,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    output logic pin_level
);
    logic out_d, out_q, oen_d, oen_q, lvl_d, lvl_q;

    // drive selection
    always_comb begin
        out_d = 1'h0;
        oen_d = 1'h1; // hi-z until the mode is settled [R6] [R9]
        if (ready) begin
            if (!gpio_sel) begin
                out_d = func_out; // function owns the pin [R19]
                oen_d = !func_drive;
            end else if (gpio_en) begin // [R7]
                if (od_sel && data_bit) begin
                    oen_d = 1'h1; // input, or released open drain [R8]
                end else begin
                    out_d = data_bit; // [R10]
                    oen_d = od_sel ? data_bit : 1'h0; // pseudo open drain drives low only
                end
            end
        end
        lvl_d = pin_in; // [R11]
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            out_q <= 1'h0;
            oen_q <= 1'h1;
            lvl_q <= 1'h0;
        end else begin
            out_q <= out_d;
            oen_q <= oen_d;
            lvl_q <= lvl_d;
        end
    end

    assign pin_out = out_q;
    assign pin_oe_n = oen_q;
    assign pin_level = lvl_q;

    pin_hiz_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
        !$past(ready) |-> pin_oe_n) else $error("pin driven before mode known");
    od_input_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
        (ready && gpio_sel && gpio_en && od_sel && data_bit) |=> pin_oe_n)
        else $error("gpio input driven");
endmodule
`default_nettype wire

// File: spg_top.sv
// top: pin function selection, modem handshake and alarm for seven shared pins
`timescale 1ns/10ps
`default_nettype none
module spg_top
    import spg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic mode_known,
    input wire spg_cfg_t cfg,
    input wire spg_gpio_t gpio,
    input wire logic rts_pin_n,
    input wire logic carrier_present,
    input wire logic [3:0] alarm_src,
    input wire logic irq_req,
    input wire logic irq_level,
    input wire logic clk_div_out,
    input wire logic spi_sdo_data,
    input wire logic spi_sdo_drive,
    input wire logic uart_tx_data,
    input wire logic carrier_flags_clr,
    input wire logic [6:0] pin_in,
    output logic [6:0] pin_out,
    output logic [6:0] pin_oe_n,
    output logic [6:0] gpio_read_data,
    output logic send_request,
    output logic carrier_rise_flag,
    output logic carrier_fall_flag,
    output logic alarm_pin_n,
    output logic soft_irq_break_req,
    output logic spi_access_en,
    output logic clear_in,
    output logic uart_rx_in,
    output logic spi_cs_n_in,
    output logic spi_sdi_in
);
    spg_state_t st_d, st_q;
    logic cd_d, cd_q, rise_d, rise_q, fall_d, fall_q;
    logic rts_d, rts_q, alm_d, alm_q, brk_d, brk_q, spi_d, spi_q, clr_d, clr_q;
    logic [6:0] gsel, fdrv, fout;
    logic ready;

    // mode determination gate; stays ready once set
    always_comb begin
        case (st_q)
            SPG_WAIT: st_d = mode_known ? SPG_RUN : SPG_WAIT; // [R6]
            SPG_RUN: st_d = SPG_RUN;
            default: st_d = SPG_WAIT;
        endcase
    end
    assign ready = (st_q == SPG_RUN);

    // gpio eligibility per pin
    always_comb begin
        gsel = 7'h00;
        gsel[SPG_P_CS] = cfg.uart_register_mode_bit; // [R12] [R5]
        gsel[SPG_P_SDI] = cfg.uart_register_mode_bit && !cfg.clear_input_enable; // [R12]
        gsel[SPG_P_SDO] = cfg.uart_register_mode_bit && !cfg.irq_pin_enable; // [R12]
        gsel[SPG_P_UIN] = cfg.uart_disable_bit; // [R13]
        gsel[SPG_P_UOUT] = cfg.uart_disable_bit && !cfg.irq_pin_enable; // [R13]
        gsel[SPG_P_CD] = cfg.uart_disable_bit; // [R13]
        gsel[SPG_P_CLK] = !cfg.clock_output_enable
            && (cfg.uart_register_mode_bit || cfg.uart_disable_bit); // [R14]
    end

    // function drive per pin when not gpio
    always_comb begin
        fdrv = 7'h00;
        fout = 7'h00;
        fdrv[SPG_P_CLK] = 1'h1;
        fout[SPG_P_CLK] = clk_div_out; // [R14]
        fdrv[SPG_P_CD] = 1'h1;
        fout[SPG_P_CD] = cd_q; // [R2]
        fdrv[SPG_P_UOUT] = 1'h1;
        if (cfg.uart_disable_bit && cfg.irq_pin_enable) begin
            fout[SPG_P_UOUT] = irq_req ~^ irq_level; // [R15]
        end else begin
            fout[SPG_P_UOUT] = uart_tx_data;
        end
        if (cfg.uart_register_mode_bit) begin
            fdrv[SPG_P_SDO] = 1'h1;
            fout[SPG_P_SDO] = irq_req ~^ irq_level; // [R16]
        end else begin
            fdrv[SPG_P_SDO] = spi_sdo_drive;
            fout[SPG_P_SDO] = spi_sdo_data;
        end
    end

    // handshake, alarm and flags
    always_comb begin
        cd_d = carrier_present; // [R2]
        rise_d = rise_q;
        fall_d = fall_q;
        if (carrier_flags_clr) begin
            rise_d = 1'h0;
            fall_d = 1'h0;
        end
        // set beats clear
        if (carrier_present && !cd_q) begin
            rise_d = 1'h1; // [R2]
        end
        if (!carrier_present && cd_q) begin
            fall_d = 1'h1; // [R2]
        end
        rts_d = !rts_pin_n || cfg.send_request_bit; // [R1]
        alm_d = !(|alarm_src); // [R3]
        brk_d = !cfg.uart_disable_bit && cfg.soft_interrupt_enable && irq_req; // [R4]
        spi_d = !cfg.uart_register_mode_bit; // [R18]
        clr_d = cfg.uart_register_mode_bit && cfg.clear_input_enable
            && pin_in[SPG_P_SDI]; // [R17]
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= SPG_WAIT;
            cd_q <= 1'h0;
            rise_q <= 1'h0;
            fall_q <= 1'h0;
            rts_q <= 1'h0;
            alm_q <= 1'h1;
            brk_q <= 1'h0;
            spi_q <= 1'h1;
            clr_q <= 1'h0;
        end else begin
            st_q <= st_d;
            cd_q <= cd_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
            rts_q <= rts_d;
            alm_q <= alm_d;
            brk_q <= brk_d;
            spi_q <= spi_d;
            clr_q <= clr_d;
        end
    end

    assign carrier_rise_flag = rise_q;
    assign carrier_fall_flag = fall_q;
    assign send_request = rts_q;
    assign alarm_pin_n = alm_q;
    assign soft_irq_break_req = brk_q;
    assign spi_access_en = spi_q;
    assign clear_in = clr_q;
    // inputs for the comm engines come from registered pin levels
    assign uart_rx_in = gpio_read_data[SPG_P_UIN];
    assign spi_cs_n_in = gpio_read_data[SPG_P_CS];
    assign spi_sdi_in = gpio_read_data[SPG_P_SDI];

    // one cell per shared pin
    genvar i;
    generate
        for (i = 0; i < SPG_NPIN; i++) begin : g_pin
            spg_pin_cell u_cell (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .ready(ready),
                .gpio_sel(gsel[i]),
                .func_drive(fdrv[i]),
                .func_out(fout[i]),
                .gpio_en(gpio.en[i]),
                .od_sel(gpio.pin_open_drain_select[i]),
                .data_bit(gpio.data[i]),
                .pin_in(pin_in[i]),
                .pin_out(pin_out[i]),
                .pin_oe_n(pin_oe_n[i]),
                .pin_level(gpio_read_data[i])
            );
        end
    endgenerate

    // checks sample registered outputs one edge after their cause
    rts_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
        $past(rst_n) |-> send_request == (!$past(rts_pin_n) || $past(cfg.send_request_bit)))
        else $error("send request mismatch");
    cd_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
        (carrier_present && !cd_q) |=> carrier_rise_flag) else $error("rise lost");
    cd_fall_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
        (!carrier_present && cd_q) |=> carrier_fall_flag) else $error("fall lost");
    // clear only wins when no carrier edge of the flag's own direction lands in the same cycle
    flag_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
        (carrier_flags_clr && !(carrier_present && !cd_q)) |=> !carrier_rise_flag)
        else $error("rise flag not cleared");
    cd_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
        (ready && !cfg.uart_disable_bit) |=> (!pin_oe_n[SPG_P_CD]
        && pin_out[SPG_P_CD] == $past(cd_q))) else $error("carrier pin wrong");
    alarm_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
        (|alarm_src) |=> !alarm_pin_n) else $error("alarm not low");
    spi_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R18]
        cfg.uart_register_mode_bit |=> !spi_access_en) else $error("spi not blocked");
    cs_gpio_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
        (ready && !cfg.uart_register_mode_bit) |=> !pin_oe_n[SPG_P_CS] == 1'h0)
        else $error("cs driven in spi mode");
    clk_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
        (ready && cfg.clock_output_enable) |=> (!pin_oe_n[SPG_P_CLK]
        && pin_out[SPG_P_CLK] == $past(clk_div_out))) else $error("clock pin wrong");
    uout_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R15]
        (ready && cfg.uart_disable_bit && cfg.irq_pin_enable) |=> (!pin_oe_n[SPG_P_UOUT]
        && pin_out[SPG_P_UOUT] == ($past(irq_req) ~^ $past(irq_level))))
        else $error("uart out not irq");
    sdo_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
        (ready && cfg.uart_register_mode_bit && cfg.irq_pin_enable) |=> (!pin_oe_n[SPG_P_SDO]
        && pin_out[SPG_P_SDO] == ($past(irq_req) ~^ $past(irq_level))))
        else $error("sdo not irq");
    clr_map_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
        $past(rst_n) |-> clear_in == ($past(cfg.uart_register_mode_bit)
        && $past(cfg.clear_input_enable) && $past(pin_in[SPG_P_SDI])))
        else $error("clear input wrong");
    uin_func_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R19]
        (ready && !cfg.uart_disable_bit) |=> pin_oe_n[SPG_P_UIN])
        else $error("uart input driven by gpio");
    mode_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
        !ready |=> (pin_oe_n == 7'h7F)) else $error("pins driven before mode");
    readback_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
        $past(rst_n) |-> gpio_read_data == $past(pin_in))
        else $error("readback wrong");
    brk_req_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
        (cfg.uart_disable_bit) |=> !soft_irq_break_req) else $error("break in spi");
endmodule
`default_nettype wire

// File: spg_host_model.sv
// host side of the seven shared pins: drivers, resistive ties and wire levels
`timescale 1ns/10ps
`default_nettype none
module spg_host_model
    import spg_pkg::*;
(
    input wire logic [6:0] pin_out,
    input wire logic [6:0] pin_oe_n,
    input wire logic [6:0] host_val,
    input wire logic [6:0] host_en,
    output logic [6:0] pin_in
);
    // device drive wins; an undriven pin floats up to its pull-up tie
    always_comb begin
        for (int i = 0; i < SPG_NPIN; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (host_en[i]) begin
                pin_in[i] = host_val[i];
            end else begin
                pin_in[i] = 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// testbench: pin selection, gpio drive and readback, modem and alarm levels
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import spg_pkg::*;
    logic ref_clk = 0, rst_n = 0, mode_known = 0, rts_pin_n = 1, carrier_present = 0;
    logic irq_req = 0, irq_level = 0, clk_div_out = 0, spi_sdo_data = 0, spi_sdo_drive = 0;
    logic uart_tx_data = 0, carrier_flags_clr = 0;
    logic [3:0] alarm_src = 4'h0;
    logic [6:0] host_val = 7'h00, host_en = 7'h00;
    spg_cfg_t cfg = '0;
    spg_gpio_t gpio = '0;
    wire logic [6:0] pin_in, pin_out, pin_oe_n, rd;
    wire logic sreq, rise, fall, alm_n, brk, spi_en, clr_in, rx_in, cs_in, sdi_in;
    int n_mismatch = 0, checks_done = 0;

    spg_top u_spg_top(.ref_clk(ref_clk), .rst_n(rst_n), .mode_known(mode_known), .cfg(cfg),
        .gpio(gpio), .rts_pin_n(rts_pin_n), .carrier_present(carrier_present),
        .alarm_src(alarm_src), .irq_req(irq_req), .irq_level(irq_level),
        .clk_div_out(clk_div_out), .spi_sdo_data(spi_sdo_data), .spi_sdo_drive(spi_sdo_drive),
        .uart_tx_data(uart_tx_data), .carrier_flags_clr(carrier_flags_clr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .gpio_read_data(rd), .send_request(sreq),
        .carrier_rise_flag(rise), .carrier_fall_flag(fall), .alarm_pin_n(alm_n),
        .soft_irq_break_req(brk), .spi_access_en(spi_en), .clear_in(clr_in),
        .uart_rx_in(rx_in), .spi_cs_n_in(cs_in), .spi_sdi_in(sdi_in));
    spg_host_model u_spg_host_model(.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .host_val(host_val), .host_en(host_en), .pin_in(pin_in));

    // 25 MHz reference clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // inputs move and outputs are sampled 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [6:0] seen, input logic [6:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hang guard: only fires if the main sequence never finishes
    initial begin
        #2000000;
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        #1 rst_n = 1;
        step(1);
        chk("oe_rst", pin_oe_n, 7'h7F);
        chk("alarm_rst", {6'h00, alm_n}, 7'h01);
        // every pin eligible, push-pull low, but mode not known yet
        cfg = 7'h60;
        gpio = {7'h7F, 7'h00, 7'h00};
        step(3);
        chk("oe_nomode", pin_oe_n, 7'h7F);
        mode_known = 1;
        step(1);
        chk("oe_gate", pin_oe_n, 7'h7F);
        step(2);
        chk("oe_run", pin_oe_n, 7'h00);
        $display("test mode gate done");
        // push-pull patterns, read back from the wire
        for (int k = 0; k < 2; k++) begin
            gpio.data = k ? 7'h2A : 7'h55;
            step(3);
            chk("out_pp", pin_out, gpio.data);
            chk("rd_pp", rd, gpio.data);
        end
        // upper pins inputs, lower pins pseudo open drain low
        gpio = {7'h7F, 7'h7F, 7'h70};
        host_en = 7'h70;
        host_val = 7'h50;
        step(3);
        chk("oe_od", pin_oe_n, 7'h70);
        chk("out_od", pin_out & 7'h0F, 7'h00);
        chk("rd_od", rd, 7'h50);
        chk("rd_bits", {4'h0, cs_in, sdi_in, rx_in}, 7'h04);
        gpio.en = 7'h00;
        step(3);
        chk("oe_noen", pin_oe_n, 7'h7F);
        $display("test gpio done");
        // register mode, uart on, irq/clear/clock functions, gpio wants low
        cfg = 7'h5E;
        gpio = {7'h7F, 7'h00, 7'h00};
        host_en = 7'h28;
        host_val = 7'h28;
        irq_req = 1;
        irq_level = 1;
        uart_tx_data = 1;
        clk_div_out = 1;
        step(3);
        chk("oe_a", pin_oe_n, 7'h28);
        chk("out_a", pin_out & 7'h57, 7'h15);
        chk("fn_a", {2'h0, clr_in, rx_in, spi_en, brk, sreq}, 7'h1A);
        chk("spi_a", {6'h00, spi_en}, 7'h00);
        chk("brk_a", {6'h00, brk}, 7'h01);
        // carrier pin and sticky flags
        carrier_present = 1;
        step(2);
        chk("cd_on", {4'h0, pin_out[1], rise, fall}, 7'h06);
        carrier_present = 0;
        step(2);
        chk("cd_off", {4'h0, pin_out[1], rise, fall}, 7'h03);
        carrier_flags_clr = 1;
        step(1);
        carrier_flags_clr = 0;
        step(1);
        chk("cd_clr", {5'h00, rise, fall}, 7'h00);
        $display("test register mode done");
        // spi mode, uart disabled, irq on uart output, active-low level
        cfg = 7'h2A;
        gpio = {7'h7F, 7'h00, 7'h7F};
        host_en = 7'h20;
        irq_level = 0;
        step(3);
        chk("oe_b", pin_oe_n, 7'h70);
        chk("out_b", pin_out & 7'h0F, 7'h0B);
        chk("spi_b", {5'h00, spi_en, brk}, 7'h02);
        $display("test spi mode done");
        // request to send by pin or by bit
        for (int k = 0; k < 4; k++) begin
            rts_pin_n = k[0];
            cfg.send_request_bit = k[1];
            step(2);
            chk("sreq", {6'h00, sreq}, {6'h00, ~k[0] | k[1]});
        end
        alarm_src = 4'h4;
        step(2);
        chk("alarm", {6'h00, alm_n}, 7'h00);
        $display("test handshake done");
        final_report();
    end
endmodule
`default_nettype wire
